// [rtl/ltw_pkg.sv]
/*
 * Constants of the timebase, watchdog and capture timer: register indices,
 * field positions, reset values and cycle counts.
 * Assumes the counter clock is the oscillator clock that feeds aclk.
 */
package ltw_pkg;
    localparam int ADDR_W = 8;
    // Printed offsets are register indices; byte address is four times the index.
    localparam logic [ADDR_W-1:0] CSR_INDEX = 8'h0b;
    localparam logic [ADDR_W-1:0] CAP_INDEX = 8'h0c;
    localparam logic [ADDR_W-1:0] CSR_ADDR = 8'(CSR_INDEX * 4);
    localparam logic [ADDR_W-1:0] CAP_ADDR = 8'(CAP_INDEX * 4);

    localparam int CNT_W = 13;
    localparam logic [CNT_W-1:0] CNT_TERMINAL = 13'h1f3f;
    localparam logic [CNT_W-1:0] CNT_RESET = 13'h0000;
    localparam int CAP_LSB = 5;

    // Control/status field positions.
    localparam int BIT_CAP_IE = 7;
    localparam int BIT_CAP_FLAG = 6;
    localparam int BIT_TB_SEL = 5;
    localparam int BIT_TB_IE = 4;
    localparam int BIT_TB_FLAG = 3;
    localparam int BIT_WDG_RF = 2;
    localparam int BIT_WDG_EN = 1;
    localparam int BIT_WDG_DLY = 0;

    localparam logic [7:0] CAP_RESET = 8'h00;
    localparam int WAKE_SHORT_CYCLES = 256;
    localparam int WAKE_LONG_CYCLES = 512;
    localparam int WAKE_W = 10;

    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {LTW_RUN, LTW_HALTED, LTW_WAKE} ltw_state_t;
endpackage : ltw_pkg

// [rtl/ltw_timer.sv]
/*
 * Timebase, watchdog and input capture timer with an AXI4-Lite register slave.
 * Assumes aclk is the oscillator clock, chip_reset_req is fed back into the
 * chip reset that drives aresetn, and por_n is asserted only at power-on.
 */
// The AXI4-Lite register port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module ltw_timer
    import ltw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic [ltw_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ltw_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic capture_input_pin,
    input wire logic ext_interrupt,
    input wire logic halt_req,
    input wire logic cpu_irq_mask,
    input wire logic hw_watchdog_option,
    input wire logic reset_on_halt_option,
    input wire logic wake_delay_long,
    output logic timebase_irq,
    output logic capture_irq,
    output logic chip_reset_req
);
    import ltw_pkg::*;

    logic [CNT_W-1:0] cnt, next_cnt;
    logic tb_phase, next_tb_phase;
    logic wdg_phase, next_wdg_phase;
    logic capture_irq_enable, next_capture_irq_enable;
    logic capture_flag, next_capture_flag;
    logic timebase_select, next_timebase_select;
    logic timebase_irq_enable, next_timebase_irq_enable;
    logic timebase_flag, next_timebase_flag;
    logic watchdog_enable, next_watchdog_enable;
    logic watchdog_delay, next_watchdog_delay;
    logic watchdog_reset_flag, next_watchdog_reset_flag;
    logic wdg_elapsed, next_wdg_elapsed;
    logic [7:0] capture_register, next_capture_register;
    ltw_state_t state, next_state;
    logic [WAKE_W-1:0] wake_cnt, next_wake_cnt;
    logic next_chip_reset_req, next_timebase_irq, next_capture_irq;

    logic aw_held, next_aw_held;
    logic [ADDR_W-1:0] aw_addr, next_aw_addr;
    logic w_held, next_w_held;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_bvalid, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;

    logic cap_s1, cap_s2, cap_prev;
    logic ext_s1, ext_s2;

    logic running, wrap, tb_event, wdg_period_end, wdg_active;
    logic do_write, csr_write, read_take, csr_read, cap_read;
    logic cap_edge, forced;
    logic [7:0] csr_value;
    logic [WAKE_W-1:0] wake_limit;

    // Capture pin and wake interrupt come from pins and are synchronised first.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cap_s1 <= 1'b0;
            cap_s2 <= 1'b0;
            cap_prev <= 1'b0;
            ext_s1 <= 1'b0;
            ext_s2 <= 1'b0;
        end else begin
            cap_s1 <= capture_input_pin;
            cap_s2 <= cap_s1;
            cap_prev <= cap_s2;
            ext_s1 <= ext_interrupt;
            ext_s2 <= ext_s1;
        end
    end

    always_comb begin
        running = (state == LTW_RUN);
        wrap = running && (cnt == CNT_TERMINAL);
        tb_event = wrap && (!timebase_select || tb_phase);
        wdg_period_end = wrap && wdg_phase;
        wdg_active = watchdog_enable || hw_watchdog_option;
        do_write = (aw_held || (s_axi_awvalid && s_axi_awready)) && (w_held || (s_axi_wvalid && s_axi_wready))
                   && !s_axi_bvalid;
        csr_write = do_write && ((aw_held ? aw_addr : s_axi_awaddr) == CSR_ADDR)
                    && (w_held ? w_strb[0] : s_axi_wstrb[0]);
        read_take = s_axi_arvalid && s_axi_arready;
        csr_read = read_take && (s_axi_araddr == CSR_ADDR);
        cap_read = read_take && (s_axi_araddr == CAP_ADDR);
        cap_edge = running && (cap_s2 != cap_prev);
        forced = csr_write && wdg_active && (w_held ? w_data[BIT_WDG_RF] : s_axi_wdata[BIT_WDG_RF]);
        wake_limit = wake_delay_long ? WAKE_W'(WAKE_LONG_CYCLES - 1) : WAKE_W'(WAKE_SHORT_CYCLES - 1);
        csr_value = {capture_irq_enable, capture_flag, timebase_select, timebase_irq_enable,
                     timebase_flag, watchdog_reset_flag, watchdog_enable, watchdog_delay};
    end

    always_comb begin
        next_cnt = cnt;
        if (running) begin
            next_cnt = wrap ? CNT_RESET : cnt + 13'h0001;
        end
        next_tb_phase = wrap ? !tb_phase : tb_phase;
        next_wdg_phase = wrap ? !wdg_phase : wdg_phase;

        next_state = state;
        next_wake_cnt = wake_cnt;
        unique case (state)
            LTW_RUN: begin
                if (halt_req && !reset_on_halt_option) begin
                    next_state = LTW_HALTED;
                end
            end
            LTW_HALTED: begin
                if (ext_s2) begin
                    next_state = LTW_WAKE;
                    next_wake_cnt = '0;
                end
            end
            LTW_WAKE: begin
                next_wake_cnt = wake_cnt + 10'h001;
                if (wake_cnt == wake_limit) begin
                    next_state = LTW_RUN;
                end
            end
        endcase

        next_capture_irq_enable = capture_irq_enable;
        next_timebase_select = timebase_select;
        next_timebase_irq_enable = timebase_irq_enable;
        next_watchdog_enable = watchdog_enable;
        next_watchdog_delay = watchdog_delay;
        if (csr_write) begin
            next_capture_irq_enable = w_held ? w_data[BIT_CAP_IE] : s_axi_wdata[BIT_CAP_IE];
            next_timebase_select = w_held ? w_data[BIT_TB_SEL] : s_axi_wdata[BIT_TB_SEL];
            next_timebase_irq_enable = w_held ? w_data[BIT_TB_IE] : s_axi_wdata[BIT_TB_IE];
            next_watchdog_enable = w_held ? w_data[BIT_WDG_EN] : s_axi_wdata[BIT_WDG_EN];
        end
        if (wdg_period_end) begin
            next_watchdog_delay = 1'b0;
        end
        if (csr_write && (w_held ? w_data[BIT_WDG_DLY] : s_axi_wdata[BIT_WDG_DLY])) begin
            next_watchdog_delay = 1'b1;
        end

        // Period runs from reset whether or not the watchdog is enabled.
        next_wdg_elapsed = wdg_elapsed || (wdg_period_end && !watchdog_delay);
        // The request stays up until the chip reset it asks for arrives.
        next_chip_reset_req = chip_reset_req || (wdg_active && next_wdg_elapsed) || forced
                              || (halt_req && reset_on_halt_option && wdg_active);
        next_watchdog_reset_flag = watchdog_reset_flag;
        if (csr_read) begin
            next_watchdog_reset_flag = 1'b0;
        end
        if (next_chip_reset_req) begin
            next_watchdog_reset_flag = 1'b1;
        end

        next_timebase_flag = csr_read ? 1'b0 : timebase_flag;
        if (tb_event) begin
            next_timebase_flag = 1'b1;
        end
        next_capture_flag = cap_read ? 1'b0 : capture_flag;
        next_capture_register = capture_register;
        if (cap_edge && !capture_flag) begin
            next_capture_register = cnt[CNT_W-1:CAP_LSB];
            next_capture_flag = 1'b1;
        end
        next_timebase_irq = next_timebase_flag && timebase_irq_enable && !cpu_irq_mask;
        next_capture_irq = next_capture_flag && capture_irq_enable && !cpu_irq_mask;

        next_aw_held = aw_held;
        next_aw_addr = aw_addr;
        next_w_held = w_held;
        next_w_data = w_data;
        next_w_strb = w_strb;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        next_bvalid = s_axi_bvalid && !s_axi_bready;
        next_bresp = s_axi_bresp;
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = ((aw_held ? aw_addr : s_axi_awaddr) == CSR_ADDR) ? RESP_OKAY : RESP_SLVERR;
        end
        next_rvalid = s_axi_rvalid && !s_axi_rready;
        next_rdata = s_axi_rdata;
        next_rresp = s_axi_rresp;
        if (read_take) begin
            next_rvalid = 1'b1;
            next_rresp = RESP_OKAY;
            if (s_axi_araddr == CSR_ADDR) begin
                next_rdata = {24'h000000, csr_value};
            end else if (s_axi_araddr == CAP_ADDR) begin
                next_rdata = {24'h000000, capture_register};
            end else begin
                next_rdata = 32'h00000000;
                next_rresp = RESP_SLVERR;
            end
        end
    end

    // The reset source flag must outlive the chip reset it causes.
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            watchdog_reset_flag <= 1'b0;
        end else begin
            watchdog_reset_flag <= next_watchdog_reset_flag;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt <= CNT_RESET;
            tb_phase <= 1'b0;
            wdg_phase <= 1'b0;
            capture_irq_enable <= 1'b0;
            capture_flag <= 1'b0;
            timebase_select <= 1'b0;
            timebase_irq_enable <= 1'b0;
            timebase_flag <= 1'b0;
            watchdog_enable <= 1'b0;
            watchdog_delay <= 1'b0;
            wdg_elapsed <= 1'b0;
            capture_register <= CAP_RESET;
            state <= LTW_RUN;
            wake_cnt <= '0;
            chip_reset_req <= 1'b0;
            timebase_irq <= 1'b0;
            capture_irq <= 1'b0;
            aw_held <= 1'b0;
            aw_addr <= '0;
            w_held <= 1'b0;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_arready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            cnt <= next_cnt;
            tb_phase <= next_tb_phase;
            wdg_phase <= next_wdg_phase;
            capture_irq_enable <= next_capture_irq_enable;
            capture_flag <= next_capture_flag;
            timebase_select <= next_timebase_select;
            timebase_irq_enable <= next_timebase_irq_enable;
            timebase_flag <= next_timebase_flag;
            watchdog_enable <= next_watchdog_enable;
            watchdog_delay <= next_watchdog_delay;
            wdg_elapsed <= next_wdg_elapsed;
            capture_register <= next_capture_register;
            state <= next_state;
            wake_cnt <= next_wake_cnt;
            chip_reset_req <= next_chip_reset_req;
            timebase_irq <= next_timebase_irq;
            capture_irq <= next_capture_irq;
            aw_held <= next_aw_held;
            aw_addr <= next_aw_addr;
            w_held <= next_w_held;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            s_axi_awready <= !next_aw_held && !next_bvalid;
            s_axi_wready <= !next_w_held && !next_bvalid;
            s_axi_arready <= !next_rvalid;
            s_axi_bvalid <= next_bvalid;
            s_axi_bresp <= next_bresp;
            s_axi_rvalid <= next_rvalid;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end
    end
endmodule : ltw_timer

// [test/ltw_timer_checker.sv]
/*
 * Concurrent checks on the ports of the timebase, watchdog and capture timer.
 * Assumes one aclk domain with aresetn as its synchronous active-low reset.
 */
`timescale 1ns/1ps
module ltw_timer_checker
    import ltw_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ltw_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic halt_req,
    input wire logic cpu_irq_mask,
    input wire logic reset_on_halt_option,
    input wire logic timebase_irq,
    input wire logic capture_irq,
    input wire logic chip_reset_req
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    wire logic csr_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == CSR_ADDR;
    wire logic cap_rd = s_axi_arvalid && s_axi_arready && s_axi_araddr == CAP_ADDR;
    a_tb_irq_masked: assert property ($past(cpu_irq_mask) |-> !timebase_irq)
        else $error("timebase irq raised while masked");
    a_cap_irq_masked: assert property ($past(cpu_irq_mask) |-> !capture_irq)
        else $error("capture irq raised while masked");
    a_tb_read_clear: assert property (csr_rd && timebase_irq |-> ##2 !timebase_irq)
        else $error("timebase irq survived a status read");
    a_cap_read_clear: assert property (cap_rd && capture_irq |-> ##2 !capture_irq)
        else $error("capture irq survived a capture read");
    a_halt_no_reset: assert property (halt_req && $past(halt_req) && !reset_on_halt_option |-> !$rose(chip_reset_req))
        else $error("chip reset raised during halt");
    a_reset_req_hold: assert property (chip_reset_req |=> chip_reset_req)
        else $error("chip reset request dropped before reset");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed before it was taken");
    a_reset_quiet: assert property ($rose(aresetn) |-> !timebase_irq && !capture_irq && !chip_reset_req)
        else $error("output active right after reset");
endmodule : ltw_timer_checker

bind ltw_timer ltw_timer_checker ltw_timer_checker_inst (.aclk, .aresetn, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .halt_req, .cpu_irq_mask,
    .reset_on_halt_option, .timebase_irq, .capture_irq, .chip_reset_req);

// [test/ltw_pin_model.sv]
/*
 * Capture pin source: flips the pin a chosen number of clocks after a request.
 * Assumes fire is a one-cycle request in the aclk domain.
 */
`timescale 1ns/1ps
module ltw_pin_model (
    input wire logic aclk,
    input wire logic fire,
    input wire logic [7:0] lag,
    output logic pin
);
    logic [7:0] left = 8'h00;
    initial pin = 1'b0;
    always @(posedge aclk) begin
        if (fire) begin
            left <= lag;
        end else if (left == 8'h01) begin
            pin <= !pin;
            left <= 8'h00;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
endmodule : ltw_pin_model

// [test/test_ltw_timer.sv]
/*
 * Self-checking bench for the timer: registers, timebase, capture and watchdog.
 * Assumes the pin model and the bound checker are compiled before it.
 */
`timescale 1ns/1ps
module test_ltw_timer;
    import ltw_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, lag = 8'h01;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0, ext_interrupt = 1'b0, halt_req = 1'b0, cpu_irq_mask = 1'b0, fire = 1'b0;
    logic hw_watchdog_option = 1'b0, reset_on_halt_option = 1'b0, wake_delay_long = 1'b0, ok;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, capture_input_pin;
    logic timebase_irq, capture_irq, chip_reset_req;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [12:0] cnt = 13'h0;
    int num_errors = 0, checks_done = 0, cyc = 0, t0, c;

    always #4 aclk = !aclk;
    always @(posedge aclk) cyc <= cyc + 1;
    // Shadow of the hidden counter, used only to bound captured values.
    always @(posedge aclk) cnt <= (!aresetn || cnt == CNT_TERMINAL) ? 13'h0 : cnt + 13'h1;

    ltw_timer ltw_timer_inst (.aclk, .aresetn, .por_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .capture_input_pin, .ext_interrupt, .halt_req, .cpu_irq_mask, .hw_watchdog_option,
        .reset_on_halt_option, .wake_delay_long, .timebase_irq, .capture_irq, .chip_reset_req);
    ltw_pin_model ltw_pin_model_inst (.aclk, .fire, .lag, .pin(capture_input_pin));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic summarize;
        if (num_errors == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : summarize

    task automatic rst(input logic por);
        aresetn <= 1'b0;
        por_n <= !por;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        repeat (2) @(posedge aclk);
    endtask : rst

    task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] resp);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready && s_axi_awvalid) s_axi_awvalid <= 1'b0;
            if (s_axi_wready && s_axi_wvalid) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready && s_axi_arvalid) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        v = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic pulse_pin(input logic [7:0] n);
        lag <= n;
        fire <= 1'b1;
        @(posedge aclk);
        fire <= 1'b0;
    endtask : pulse_pin

    task automatic t_regs;
        rd(CSR_ADDR, d, r);
        chk(d, 32'h0);
        rd(CAP_ADDR, d, r);
        chk(d, {24'h0, CAP_RESET});
        rd(8'h00, d, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(8'h00, 8'hff, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        wr(CSR_ADDR, 8'hf8, r);
        rd(CSR_ADDR, d, r);
        chk(d, 32'hb0);
    endtask : t_regs

    task automatic t_cap;
        wr(CSR_ADDR, 8'h80, r);
        pulse_pin(8'h01);
        while (!capture_irq) @(posedge aclk);
        c = int'(cnt);
        cpu_irq_mask <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({31'h0, capture_irq}, 32'h0);
        cpu_irq_mask <= 1'b0;
        pulse_pin(8'h40);
        repeat (80) @(posedge aclk);
        chk({31'h0, capture_irq}, 32'h1);
        rd(CAP_ADDR, d, r);
        ok = 1'b0;
        for (int k = 0; k < 8; k++) begin
            if (d[7:0] == 8'(((c - k + 8000) % 8000) >> CAP_LSB)) ok = 1'b1;
        end
        chk({31'h0, ok}, 32'h1);
        rd(CSR_ADDR, d, r);
        chk({31'h0, d[BIT_CAP_FLAG]}, 32'h0);
    endtask : t_cap

    task automatic t_tb;
        wr(CSR_ADDR, 8'h10, r);
        while (!timebase_irq) @(posedge aclk);
        t0 = cyc;
        cpu_irq_mask <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({31'h0, timebase_irq}, 32'h0);
        cpu_irq_mask <= 1'b0;
        repeat (2) @(posedge aclk);
        chk({31'h0, timebase_irq}, 32'h1);
        rd(CSR_ADDR, d, r);
        chk({31'h0, d[BIT_TB_FLAG]}, 32'h1);
        while (!timebase_irq) @(posedge aclk);
        chk(32'(cyc - t0), 32'd8000);
    endtask : t_tb

    task automatic watchdog_period;
        rst(1'b0);
        wr(CSR_ADDR, 8'h33, r);
        while (!timebase_irq) @(posedge aclk);
        t0 = cyc;
        chk({31'h0, chip_reset_req}, 32'h0);
        rd(CSR_ADDR, d, r);
        chk({31'h0, d[BIT_WDG_DLY]}, 32'h0);
        while (!chip_reset_req) @(posedge aclk);
        chk(32'(cyc - t0), 32'd16000);
        rst(1'b0);
        rd(CSR_ADDR, d, r);
        chk(d, 32'h4);
        rd(CSR_ADDR, d, r);
        chk(d, 32'h0);
    endtask : watchdog_period

    task automatic t_late;
        rst(1'b1);
        repeat (16100) @(posedge aclk);
        chk({31'h0, chip_reset_req}, 32'h0);
        wr(CSR_ADDR, 8'h02, r);
        chk({31'h0, chip_reset_req}, 32'h1);
    endtask : t_late

    task automatic t_halt;
        rst(1'b1);
        wr(CSR_ADDR, 8'h02, r);
        repeat (15000) @(posedge aclk);
        wake_delay_long <= 1'b1;
        halt_req <= 1'b1;
        cpu_irq_mask <= 1'b1;
        repeat (3000) @(posedge aclk);
        chk({31'h0, chip_reset_req}, 32'h0);
        halt_req <= 1'b0;
        cpu_irq_mask <= 1'b0;
        ext_interrupt <= 1'b1;
        t0 = cyc;
        repeat (4) @(posedge aclk);
        ext_interrupt <= 1'b0;
        while (!chip_reset_req) @(posedge aclk);
        chk({31'h0, cyc - t0 > 1450 && cyc - t0 < 1550}, 32'h1);
    endtask : t_halt

    task automatic t_force;
        rst(1'b1);
        wr(CSR_ADDR, 8'h03, r);
        reset_on_halt_option <= 1'b1;
        halt_req <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({31'h0, chip_reset_req}, 32'h1);
        halt_req <= 1'b0;
        reset_on_halt_option <= 1'b0;
        hw_watchdog_option <= 1'b1;
        rst(1'b1);
        chk({31'h0, chip_reset_req}, 32'h0);
        wr(CSR_ADDR, 8'h04, r);
        chk({31'h0, chip_reset_req}, 32'h1);
    endtask : t_force

    initial begin
        rst(1'b1);
        t_regs();
        t_cap();
        t_tb();
        watchdog_period();
        t_late();
        t_halt();
        t_force();
        summarize();
    end

    initial begin
        #800000;
        num_errors++;
        summarize();
    end
endmodule : test_ltw_timer
